// *** scsc_pkg.sv ***
/*
 * Package: command codes, reset values, fields, states and structs.
 * Assumes a four-channel group driven by one host over a framed serial port.
 */
package scsc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Command codes
   localparam logic [7:0] CMD_DEACT  = 8'h00;
   localparam logic [7:0] CMD_SRST   = 8'h02;
   localparam logic [7:0] CMD_HRST   = 8'h04;
   localparam logic [7:0] CMD_NOP    = 8'h06;
   localparam logic [7:0] CMD_ACT    = 8'h0e;
   localparam logic [7:0] CMD_TXTS   = 8'h40;
   localparam logic [7:0] CMD_RXTS   = 8'h42;
   localparam logic [7:0] CMD_CLKS   = 8'h44;
   localparam logic [7:0] CMD_CONF   = 8'h46;
   localparam logic [7:0] CMD_CHEN   = 8'h4a;
   localparam logic [7:0] CMD_RTD    = 8'h4d;
   localparam logic [7:0] CMD_RTDC   = 8'h4f;
   localparam logic [7:0] CMD_IODIR  = 8'h54;
   localparam logic [7:0] CMD_REV    = 8'h73;
   localparam logic [7:0] CMD_XDAT   = 8'hcd;
   localparam logic [7:0] CMD_GK     = 8'he8;

   ////////////////////////////////////////////////////////////////////////////
   // Frame edge counts
   localparam logic [4:0] EDGE_BYTE  = 5'h08;
   localparam logic [4:0] EDGE_RST   = 5'h10;

   // Frame sync pulses after activate before samples are valid
   localparam logic [1:0] FS_VALID_CNT = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CONF_SIG_BIT   = 5;
   localparam int CLKS_TAB_BIT   = 7;
   localparam int CHEN_EC_LSB    = 0;
   localparam int CHEN_EC_W      = 4;
   localparam int STAT_ACT_BIT   = 7;

   // Reset values
   localparam logic [7:0] RST_CONF   = 8'h9a;
   localparam logic [7:0] RST_CHEN   = 8'h0f;
   localparam logic [6:0] RST_CLKS   = 7'h00;
   localparam logic [7:0] RST_GK     = 8'h00;
   localparam logic [6:0] RST_IODIR  = 7'h00;
   localparam logic       RST_TAB    = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      SEQ_CMD = 2'b00,
      SEQ_WR  = 2'b01,
      SEQ_RD  = 2'b10
   } scsc_seq_t;

   typedef struct packed {
      logic [7:0] tx_slot;
      logic [7:0] rx_slot;
      logic       tab;
      logic [7:0] gk;
      logic [6:0] iodir;
   } scsc_chan_t;

   typedef struct packed {
      logic fs;
      logic rst_n;
      logic sdi;
      logic cs_n;
      logic sclk;
   } scsc_pins_t;

endpackage

// *** scsc_sync.sv ***
/*
 * Two flip-flop synchroniser for a bundle of pin inputs.
 * Assumes each bit is an independent level from outside the clock domain.
 */
`timescale 1ns/1ps
module scsc_sync #(
   parameter int              W       = 1,
   parameter logic [W-1:0]    RST_VAL = '0
) (
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);

   logic [W-1:0] meta_q;

   initial begin
      if (W < 1) begin
         $error("scsc_sync: width must be at least one");
      end
   end

   // First stage feeds only the second
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// *** scsc_top.sv ***
/*
 * Serial command decoder and channel state control for one four-channel group.
 * Assumes pin inputs are asynchronous to clk and the serial clock is far slower.
 */
`timescale 1ns/1ps
//
// Summary of operation
// R01: Byte per chip-select frame, MSB first
// R02: Under 8 edges ignore; 16 edges reset
// R03: Data bytes follow command; reads finish first
// R04: Enable bits scope commands; first channel reads
// R05: Code 00h puts enabled channels standby
// R06: Standby keeps programming and serial port
// R07: Standby disables PCM unless signaling selected
// R08: Standby drops analog output enable
// R09: Standby clears channel active flag
// R10: Code 02h resets enabled channels only
// R11: Soft reset keeps slots, highways, globals
// R12: Code 04h resets whole group
// R13: Code 04h ignores channel enables
// R14: Hardware reset loads every default
// R15: Code 0Eh activates enabled channels
// R16: Samples valid after second frame sync
// R17: Even code writes, odd code reads
// R18: 4Dh reads data; 4Fh also clears
// R19: 73h returns revision; CDh transmit sample
// R20: Host sends only defined codes
// R21: Host writes zero to reserved bits
// R22: Global bits act on whole group
// R23: Code 06h does nothing
// R24: Disabled channels ignore channel commands
//
module scsc_top #(
   parameter int         N_CH     = 4,
   parameter logic [7:0] REVISION = 8'h01   // Arbitrary value
) (
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic                       serial_data_clock,
   input  wire logic                       chip_select_n,
   input  wire logic                       serial_data_io_i,
   output logic                            serial_data_io_o,
   output logic                            serial_data_io_oe,
   input  wire logic                       group_reset_n,
   input  wire logic                       frame_sync_pulse,
   input  wire logic [7:0]                 rt_data,
   input  wire logic                       rt_event,
   input  wire logic [N_CH-1:0][7:0]       tx_sample,
   output logic                            irq_pending,
   output logic [N_CH-1:0]                 channel_active_flag,
   output logic [N_CH-1:0]                 pcm_rx_enable,
   output logic [N_CH-1:0]                 pcm_tx_oe,
   output logic [N_CH-1:0]                 pcm_tx_valid,
   output logic [N_CH-1:0]                 analog_out_en,
   output logic                            pcm_signaling_select,
   output logic [7:0]                      conf_reg,
   output logic [7:0]                      chen_reg,
   output logic [6:0]                      clk_slot_reg,
   output scsc_pkg::scsc_chan_t [N_CH-1:0] chan_cfg
);

   initial begin
      if (N_CH < 1 || N_CH > scsc_pkg::CHEN_EC_W) begin
         $error("scsc_top: channel count must be 1 to 4");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   scsc_pkg::scsc_pins_t pins_raw;
   scsc_pkg::scsc_pins_t pins_s;

   assign pins_raw = '{fs: frame_sync_pulse, rst_n: group_reset_n, sdi: serial_data_io_i,
                       cs_n: chip_select_n, sclk: serial_data_clock};

   scsc_sync #(
      .W       ($bits(scsc_pkg::scsc_pins_t)),
      .RST_VAL (5'h0e)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      (pins_raw),
      .q      (pins_s)
   );

   logic sclk_p_q;
   logic cs_p_q;
   logic fs_p_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclk_p_q <= 1'b0;
         cs_p_q   <= 1'b1;
         fs_p_q   <= 1'b0;
      end else begin
         sclk_p_q <= pins_s.sclk;
         cs_p_q   <= pins_s.cs_n;
         fs_p_q   <= pins_s.fs;
      end
   end

   logic sclk_rise;
   logic cs_fall;
   logic cs_rise;
   logic fs_rise;

   assign sclk_rise = pins_s.sclk & ~sclk_p_q & ~pins_s.cs_n;
   assign cs_fall   = ~pins_s.cs_n & cs_p_q;
   assign cs_rise   = pins_s.cs_n & ~cs_p_q;
   assign fs_rise   = pins_s.fs & ~fs_p_q;

   ////////////////////////////////////////////////////////////////////////////
   // Frame engine
   logic [4:0] edge_cnt_q;
   logic [7:0] shift_in_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         edge_cnt_q <= 5'h00;
         shift_in_q <= 8'h00;
      end else if (cs_fall) begin
         edge_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
         shift_in_q <= {shift_in_q[6:0], pins_s.sdi};                 // R01
         if (edge_cnt_q < scsc_pkg::EDGE_RST) begin
            edge_cnt_q <= edge_cnt_q + 5'h01;
         end
      end
   end

   logic byte_done;
   logic frame_rst;

   // Only the last eight bits remain in the shifter
   assign byte_done = cs_rise && edge_cnt_q >= scsc_pkg::EDGE_BYTE
                      && edge_cnt_q < scsc_pkg::EDGE_RST;                // R02
   assign frame_rst = cs_rise && edge_cnt_q >= scsc_pkg::EDGE_RST;     // R02

   ////////////////////////////////////////////////////////////////////////////
   // Command decode
   scsc_pkg::scsc_seq_t seq_q;
   logic [7:0]          cmd_q;
   logic [7:0]          rd_byte_q;
   logic                cmd_strobe;
   logic                data_strobe;
   logic                grp_rst;
   logic [N_CH-1:0]     en;
   logic                any_en;
   logic [N_CH-1:0]     active_q;

   assign cmd_strobe  = byte_done && seq_q == scsc_pkg::SEQ_CMD;
   assign data_strobe = byte_done && seq_q == scsc_pkg::SEQ_WR;
   assign en          = chen_reg[N_CH-1:0];
   assign any_en      = |en;

   // Pin, command and overlong frame share one path
   assign grp_rst = ~pins_s.rst_n | frame_rst
                    | (cmd_strobe && shift_in_q == scsc_pkg::CMD_HRST);    // R12 R13

   logic [7:0] rd_mux;
   logic       is_write;
   logic       is_read;
   int         first;

   always_comb begin
      first = 0;
      for (int i = N_CH - 1; i >= 0; i--) begin
         if (en[i]) begin
            first = i;                                                    // R04
         end
      end
   end

   always_comb begin
      is_write = 1'b0;
      is_read  = 1'b1;
      rd_mux   = 8'h00;
      case (shift_in_q)                                                   // R17
         scsc_pkg::CMD_TXTS, scsc_pkg::CMD_RXTS, scsc_pkg::CMD_CLKS,
         scsc_pkg::CMD_CONF, scsc_pkg::CMD_CHEN, scsc_pkg::CMD_IODIR,
         scsc_pkg::CMD_GK: begin
            is_write = 1'b1;
            is_read  = 1'b0;
         end
         scsc_pkg::CMD_TXTS | 8'h01: begin
            rd_mux = chan_cfg[first].tx_slot;
         end
         scsc_pkg::CMD_RXTS | 8'h01: begin
            rd_mux = chan_cfg[first].rx_slot;
         end
         scsc_pkg::CMD_CLKS | 8'h01: begin
            rd_mux = {chan_cfg[first].tab, clk_slot_reg};
         end
         scsc_pkg::CMD_CONF | 8'h01: begin
            rd_mux = conf_reg;
         end
         scsc_pkg::CMD_CHEN | 8'h01: begin
            rd_mux = chen_reg;
         end
         scsc_pkg::CMD_RTD, scsc_pkg::CMD_RTDC: begin
            rd_mux = rt_data;                                             // R18
         end
         scsc_pkg::CMD_IODIR | 8'h01: begin
            rd_mux = {active_q[first], chan_cfg[first].iodir};            // R09
         end
         scsc_pkg::CMD_REV: begin
            rd_mux = REVISION;                                            // R19
         end
         scsc_pkg::CMD_XDAT: begin
            rd_mux = tx_sample[first];                                    // R19
         end
         scsc_pkg::CMD_GK | 8'h01: begin
            rd_mux = chan_cfg[first].gk;
         end
         default: begin
            is_read = 1'b0;                                               // R23 R21
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         seq_q     <= scsc_pkg::SEQ_CMD;
         cmd_q     <= 8'h00;
         rd_byte_q <= 8'h00;
      end else if (grp_rst) begin
         seq_q     <= scsc_pkg::SEQ_CMD;
         cmd_q     <= 8'h00;
      end else begin
         case (seq_q)
            scsc_pkg::SEQ_CMD: begin
               if (cmd_strobe) begin
                  cmd_q <= shift_in_q;
                  if (is_write) begin
                     seq_q <= scsc_pkg::SEQ_WR;                           // R03
                  end else if (is_read) begin
                     seq_q     <= scsc_pkg::SEQ_RD;                       // R03
                     rd_byte_q <= rd_mux;
                  end
               end
            end
            scsc_pkg::SEQ_WR: begin
               if (data_strobe) begin
                  seq_q <= scsc_pkg::SEQ_CMD;
               end
            end
            scsc_pkg::SEQ_RD: begin
               // No command taken until the byte has gone out
               if (byte_done) begin
                  seq_q <= scsc_pkg::SEQ_CMD;                             // R03
               end
            end
            default: begin
               seq_q <= scsc_pkg::SEQ_CMD;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read shifter; reloaded on each frame so a short frame can retry
   logic [7:0] out_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_q             <= 8'h00;
         serial_data_io_oe <= 1'b0;
      end else begin
         serial_data_io_oe <= seq_q == scsc_pkg::SEQ_RD && !pins_s.cs_n && !grp_rst;
         if (seq_q != scsc_pkg::SEQ_RD || cs_fall) begin
            out_q <= seq_q == scsc_pkg::SEQ_RD ? rd_byte_q : 8'h00;
         end else if (sclk_rise) begin
            out_q <= {out_q[6:0], 1'b0};                                  // R01
         end
      end
   end

   assign serial_data_io_o = out_q[7];

   ////////////////////////////////////////////////////////////////////////////
   // Global registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         conf_reg     <= scsc_pkg::RST_CONF;
         chen_reg     <= scsc_pkg::RST_CHEN;
         clk_slot_reg <= scsc_pkg::RST_CLKS;
      end else if (grp_rst) begin
         conf_reg     <= scsc_pkg::RST_CONF;                              // R14
         chen_reg     <= scsc_pkg::RST_CHEN;                              // R14
         clk_slot_reg <= scsc_pkg::RST_CLKS;                              // R14
      end else if (data_strobe) begin
         case (cmd_q)
            scsc_pkg::CMD_CONF: begin
               conf_reg <= shift_in_q;                                    // R22
            end
            scsc_pkg::CMD_CHEN: begin
               chen_reg <= shift_in_q;
            end
            scsc_pkg::CMD_CLKS: begin
               if (any_en) begin
                  clk_slot_reg <= shift_in_q[6:0];                        // R22
               end
            end
            default: begin
               chen_reg <= chen_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pcm_signaling_select <= 1'b0;
      end else begin
         pcm_signaling_select <= conf_reg[scsc_pkg::CONF_SIG_BIT];
      end
   end

   // Real-time data interrupt; a new event beats a clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_pending <= 1'b0;
      end else if (grp_rst) begin
         irq_pending <= 1'b0;
      end else if (rt_event) begin
         irq_pending <= 1'b1;
      end else if (cmd_strobe && shift_in_q == scsc_pkg::CMD_RTDC) begin
         irq_pending <= 1'b0;                                             // R18
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel state
   for (genvar i = 0; i < N_CH; i++) begin : g_ch
      logic       srst;
      logic       act_cmd;
      logic       deact_cmd;
      logic [1:0] fs_cnt_q;
      logic       valid_q;

      assign srst      = cmd_strobe && shift_in_q == scsc_pkg::CMD_SRST && en[i];   // R10
      assign act_cmd   = cmd_strobe && shift_in_q == scsc_pkg::CMD_ACT && en[i];    // R15 R24
      assign deact_cmd = cmd_strobe && shift_in_q == scsc_pkg::CMD_DEACT && en[i];  // R05 R24

      // Soft reset leaves this state alone
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            chan_cfg[i].tx_slot <= 8'(i);
            chan_cfg[i].rx_slot <= 8'(i);
            chan_cfg[i].tab     <= scsc_pkg::RST_TAB;
            chan_cfg[i].gk      <= scsc_pkg::RST_GK;
         end else if (grp_rst) begin
            chan_cfg[i].tx_slot <= 8'(i);                                 // R14
            chan_cfg[i].rx_slot <= 8'(i);
            chan_cfg[i].tab     <= scsc_pkg::RST_TAB;
            chan_cfg[i].gk      <= scsc_pkg::RST_GK;
         end else if (data_strobe && en[i]) begin                         // R04 R11
            case (cmd_q)
               scsc_pkg::CMD_TXTS: chan_cfg[i].tx_slot <= shift_in_q;
               scsc_pkg::CMD_RXTS: chan_cfg[i].rx_slot <= shift_in_q;
               scsc_pkg::CMD_CLKS: chan_cfg[i].tab     <= shift_in_q[scsc_pkg::CLKS_TAB_BIT];
               scsc_pkg::CMD_GK:   chan_cfg[i].gk      <= shift_in_q;
               default: chan_cfg[i].gk <= chan_cfg[i].gk;
            endcase
         end
      end

      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            chan_cfg[i].iodir <= scsc_pkg::RST_IODIR;
         end else if (grp_rst || srst) begin
            chan_cfg[i].iodir <= scsc_pkg::RST_IODIR;                     // R10
         end else if (data_strobe && en[i] && cmd_q == scsc_pkg::CMD_IODIR) begin
            chan_cfg[i].iodir <= shift_in_q[6:0];
         end
      end

      // Activation and frame sync counting
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            active_q[i] <= 1'b0;
            fs_cnt_q    <= 2'h0;
            valid_q     <= 1'b0;
         end else if (grp_rst || srst || deact_cmd) begin
            active_q[i] <= 1'b0;                                          // R09 R05
            fs_cnt_q    <= 2'h0;
            valid_q     <= 1'b0;
         end else if (act_cmd) begin
            active_q[i] <= 1'b1;                                          // R15
            fs_cnt_q    <= 2'h0;
            valid_q     <= 1'b0;
         end else if (active_q[i] && fs_rise && fs_cnt_q < scsc_pkg::FS_VALID_CNT) begin
            fs_cnt_q <= fs_cnt_q + 2'h1;
            valid_q  <= fs_cnt_q == scsc_pkg::FS_VALID_CNT - 2'h1;        // R16
         end
      end

      // Pin controls lag state by one cycle to come from flops
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            pcm_rx_enable[i] <= 1'b0;
            pcm_tx_oe[i]     <= 1'b0;
            pcm_tx_valid[i]  <= 1'b0;
            analog_out_en[i] <= 1'b0;
         end else begin
            pcm_rx_enable[i] <= active_q[i] | pcm_signaling_select;       // R07 R06
            pcm_tx_oe[i]     <= active_q[i] | pcm_signaling_select;       // R07
            pcm_tx_valid[i]  <= active_q[i] & valid_q;                    // R16
            analog_out_en[i] <= active_q[i];                              // R08
         end
      end
   end

   assign channel_active_flag = active_q;

endmodule

// *** scsc_top_asserts.sv ***
/*
 * Checker for channel state, data enable, interrupt and reset values.
 * Assumes it is bound to scsc_top and sees only its ports.
 */
`timescale 1ns/1ps
module scsc_top_asserts #(
   parameter int N_CH = 4
) (
   input wire logic            clk,
   input wire logic            resetn,
   input wire logic            chip_select_n,
   input wire logic            group_reset_n,
   input wire logic            frame_sync_pulse,
   input wire logic            rt_event,
   input wire logic            serial_data_io_oe,
   input wire logic            irq_pending,
   input wire logic [N_CH-1:0] channel_active_flag,
   input wire logic [N_CH-1:0] pcm_rx_enable,
   input wire logic [N_CH-1:0] pcm_tx_oe,
   input wire logic [N_CH-1:0] pcm_tx_valid,
   input wire logic [N_CH-1:0] analog_out_en,
   input wire logic            pcm_signaling_select,
   input wire logic [7:0]      conf_reg,
   input wire logic [7:0]      chen_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   ////////////////////////////////////////////////////////////////////////////
   // Raw frame sync rises while channel 0 active
   logic       fs_d_q;
   logic [1:0] fs_seen_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fs_d_q    <= 1'b0;
         fs_seen_q <= 2'h0;
      end else begin
         fs_d_q <= frame_sync_pulse;
         if (!channel_active_flag[0]) begin
            fs_seen_q <= 2'h0;
         end else if (frame_sync_pulse && !fs_d_q && fs_seen_q != 2'h2) begin
            fs_seen_q <= fs_seen_q + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_port_idle;
      (chip_select_n && group_reset_n) [*8];
   endsequence
   sequence s_pin_reset;
      (!group_reset_n) [*6];
   endsequence

   a_analog_follows: assert property (1'b1 |=> analog_out_en == $past(channel_active_flag))
      else $error("analog enable does not follow channel state");
   a_standby_pcm_off: assert property ((channel_active_flag == '0 && !pcm_signaling_select) [*3]
      |-> pcm_rx_enable == '0 && pcm_tx_oe == '0) else $error("pcm left on in standby");
   a_valid_needs_act: assert property ((pcm_tx_valid & ~$past(channel_active_flag)) == '0)
      else $error("pcm valid without active channel");
   a_valid_two_fs: assert property ($rose(pcm_tx_valid[0]) |-> fs_seen_q == 2'h2)
      else $error("pcm valid before second frame sync");
   a_oe_idle_off: assert property (chip_select_n [*6] |-> !serial_data_io_oe)
      else $error("data output driven without select");
   a_irq_set_event: assert property (rt_event |=> irq_pending)
      else $error("event did not raise interrupt");
   a_pin_reset_defaults: assert property (s_pin_reset |-> conf_reg == scsc_pkg::RST_CONF
      && chen_reg == scsc_pkg::RST_CHEN && channel_active_flag == '0) else $error("reset values missing");
   a_idle_regs_stable: assert property (s_port_idle |-> $stable(chen_reg) && $stable(conf_reg))
      else $error("register changed with port idle");
endmodule

bind scsc_top scsc_top_asserts #(.N_CH(N_CH)) u_asserts (.clk(clk), .resetn(resetn),
   .chip_select_n(chip_select_n), .group_reset_n(group_reset_n), .frame_sync_pulse(frame_sync_pulse),
   .rt_event(rt_event), .serial_data_io_oe(serial_data_io_oe), .irq_pending(irq_pending),
   .channel_active_flag(channel_active_flag), .pcm_rx_enable(pcm_rx_enable), .pcm_tx_oe(pcm_tx_oe),
   .pcm_tx_valid(pcm_tx_valid), .analog_out_en(analog_out_en),
   .pcm_signaling_select(pcm_signaling_select), .conf_reg(conf_reg), .chen_reg(chen_reg));

// *** scsc_host.sv ***
/*
 * Host model for the serial control port: one byte per select frame.
 * Assumes the bench resolves the data line and drives clk at 10 MHz.
 */
`timescale 1ns/1ps
module scsc_host (
   input  wire logic clk,
   input  wire logic line,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi
);
   // Serial clock rests high outside frames
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Extra leading edges carry ones; 800 ns serial clock period
   task automatic frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      @(negedge clk) cs_n = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = n - 1; i >= 0; i--) begin
         sdi  = (i < 8) ? tx[i] : 1'b1;
         sclk = 1'b0;
         repeat (4) @(negedge clk);
         rx   = {rx[6:0], line};
         sclk = 1'b1;
         repeat (4) @(negedge clk);
      end
      cs_n = 1'b1;
      sdi  = ~sdi; // Stale bit must not pass for held data
      repeat (8) @(negedge clk);
   endtask
endmodule

// *** tb_top.sv ***
/*
 * Testbench: command sequences through the host model.
 * Assumes scsc_host and the bound checker are compiled beforehand.
 */
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] REV = 8'h5c; // Arbitrary value
   logic clk, resetn, group_reset_n, frame_sync_pulse, rt_event, sclk, cs_n, host_sdi, line;
   logic serial_data_io_o, serial_data_io_oe, irq_pending, pcm_signaling_select;
   logic [3:0] channel_active_flag, pcm_rx_enable, pcm_tx_oe, pcm_tx_valid, analog_out_en;
   logic [7:0] rt_data, conf_reg, chen_reg;
   logic [6:0] clk_slot_reg;
   logic [3:0][7:0] tx_sample;
   scsc_pkg::scsc_chan_t [3:0] chan_cfg;
   int miscompares = 0;
   int checked     = 0;

   assign line = serial_data_io_oe ? serial_data_io_o : host_sdi;

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   scsc_host u_host (.clk(clk), .line(line), .sclk(sclk), .cs_n(cs_n), .sdi(host_sdi));

   scsc_top #(.N_CH(4), .REVISION(REV)) u_dut (.clk(clk), .resetn(resetn), .serial_data_clock(sclk),
      .chip_select_n(cs_n), .serial_data_io_i(line), .serial_data_io_o(serial_data_io_o),
      .serial_data_io_oe(serial_data_io_oe), .group_reset_n(group_reset_n),
      .frame_sync_pulse(frame_sync_pulse), .rt_data(rt_data), .rt_event(rt_event), .tx_sample(tx_sample),
      .irq_pending(irq_pending), .channel_active_flag(channel_active_flag), .pcm_rx_enable(pcm_rx_enable),
      .pcm_tx_oe(pcm_tx_oe), .pcm_tx_valid(pcm_tx_valid), .analog_out_en(analog_out_en),
      .pcm_signaling_select(pcm_signaling_select), .conf_reg(conf_reg), .chen_reg(chen_reg),
      .clk_slot_reg(clk_slot_reg), .chan_cfg(chan_cfg));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] c);
      logic [7:0] r;
      u_host.frame(c, 8, r);
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      u_host.frame(c, 8, r);
      u_host.frame(d, 8, r);
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      logic [7:0] r;
      u_host.frame(c, 8, r);
      u_host.frame(8'h00, 8, d);
   endtask
   task automatic fs_pulse;
      @(negedge clk) frame_sync_pulse = 1'b1;
      repeat (4) @(negedge clk);
      frame_sync_pulse = 1'b0;
      repeat (12) @(negedge clk);
   endtask
   task automatic print_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      print_verdict;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Defined codes only, reserved bits zero
   initial begin
      logic [7:0] v;
      resetn = 1'b0;
      group_reset_n = 1'b1;
      frame_sync_pulse = 1'b0;
      rt_event = 1'b0;
      rt_data = 8'h6b;
      tx_sample = {8'h44, 8'h33, 8'h22, 8'h11};
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      chk({conf_reg, chen_reg, 1'b0, clk_slot_reg, chan_cfg[3].tx_slot}, 32'h9a0f0003);
      rd(8'h73, v);
      chk(v, REV);
      wr(8'h4a, 8'h05);
      rd(8'h4b, v);
      chk(v[3:0], 4'h5);
      u_host.frame(8'h0e, 6, v);
      chk(channel_active_flag, 4'h0);
      cmd(8'h0e);
      chk(channel_active_flag, 4'h5);
      fs_pulse;
      chk(pcm_tx_valid, 4'h0);
      fs_pulse;
      chk(pcm_tx_valid, 4'h5);
      wr(8'h4a, 8'h01);
      cmd(8'h00);
      chk(channel_active_flag, 4'h4);
      chk({pcm_rx_enable[0], pcm_tx_oe[0], analog_out_en[0], analog_out_en[2]}, 4'h1);
      wr(8'h46, 8'hba);
      chk({pcm_signaling_select, pcm_rx_enable[0], pcm_tx_oe[0]}, 3'h7);
      cmd(8'h06);
      chk({conf_reg, chen_reg, channel_active_flag}, 20'hba014);
      @(negedge clk) rt_event = 1'b1;
      @(negedge clk) rt_event = 1'b0;
      rd(8'h4d, v);
      chk({v, 7'h00, irq_pending}, 16'h6b01);
      rd(8'h4f, v);
      chk({v, 7'h00, irq_pending}, 16'h6b00);
      wr(8'h4a, 8'h06);
      rd(8'hcd, v);
      chk(v, 8'h22);
      wr(8'h40, 8'h23);
      chk({chan_cfg[2].tx_slot, chan_cfg[1].tx_slot, chan_cfg[0].tx_slot}, 24'h232300);
      cmd(8'h0e);
      chk(channel_active_flag, 4'h6);
      wr(8'h4a, 8'h02);
      cmd(8'h02);
      chk({channel_active_flag, chan_cfg[1].tx_slot, conf_reg}, 20'h423ba);
      wr(8'h4a, 8'h00);
      cmd(8'h04);
      chk({conf_reg, chen_reg, chan_cfg[1].tx_slot}, 24'h9a0f01);
      wr(8'h46, 8'h00);
      u_host.frame(8'h46, 16, v);
      chk(conf_reg, 8'h9a);
      wr(8'h4a, 8'h03);
      group_reset_n = 1'b0;
      repeat (8) @(negedge clk);
      group_reset_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(chen_reg, 8'h0f);
      print_verdict;
   end
endmodule
